// ==== verilog/scmc_map.vh ====
// register map, field positions, reset values and timing counts of the clock mode control
`ifndef SCMC_MAP_VH
`define SCMC_MAP_VH

// register indices on the plain register port
`define SCMC_ADDR_W          2
`define SCMC_ADDR_SCC        2'h0
`define SCMC_ADDR_FAST_RC    2'h1
`define SCMC_ADDR_FAST_XT    2'h2
`define SCMC_ADDR_SLOW_XT    2'h3

// system clock control fields
`define SCMC_SCC_CKS_HI      7
`define SCMC_SCC_CKS_LO      5
`define SCMC_SCC_FHS         3
`define SCMC_SCC_FSS         2
`define SCMC_SCC_FKEEP       1
`define SCMC_SCC_SKEEP       0
`define SCMC_CKS_SLOW        3'h7
`define SCMC_CKS_RST         3'h0

// fast rc oscillator control fields
`define SCMC_FAST_INTERNAL_RC_SEL_HI     3
`define SCMC_FAST_INTERNAL_RC_SEL_LO     2
`define SCMC_FAST_INTERNAL_RC_FLAG       1
`define SCMC_FAST_INTERNAL_RC_EN         0
`define SCMC_FAST_INTERNAL_RC_SEL_RST    2'h0
`define SCMC_FAST_INTERNAL_RC_EN_RST     1'h1

// fast crystal oscillator control fields
`define SCMC_HXT_MODE        2
`define SCMC_HXT_FLAG        1
`define SCMC_HXT_EN          0

// slow crystal oscillator control fields
`define SCMC_LXT_SPEED       2
`define SCMC_LXT_FLAG        1
`define SCMC_LXT_EN          0
`define SCMC_LXT_SPEED_VAL   1'h1

// clock switch delay: whole current system periods, then the fractional tail
`define SCMC_SW_SYS_PERIODS  3'h4
`define SCMC_SW_TAIL_CYC     2'h2

// power modes
`define SCMC_MODE_RUN        3'h0
`define SCMC_MODE_SLEEP      3'h1
`define SCMC_MODE_IDLE_SLOW_ONLY      3'h2
`define SCMC_MODE_IDLE_BOTH_OSC      3'h3
`define SCMC_MODE_IDLE_FAST_ONLY      3'h4

`define SCMC_ZERO8           8'h00

`endif

// ==== verilog/scmc_stab.v ====
// oscillator stabilisation timer producing a stable flag
`timescale 1ns/1ns
module scmc_stab #(
  parameter CNT_W       = 8,
  parameter STAB_CYCLES = 16
) (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // control
  input  wire run,
  input  wire restart,
  // status
  output reg  stable
);

  localparam [CNT_W-1:0] STAB_LAST = STAB_CYCLES - 1;
  localparam [CNT_W-1:0] CNT_ZERO  = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE   = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] count;

  // a stopped oscillator or a fresh enable clears the flag before it can rise again
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count  <= CNT_ZERO;
      stable <= 1'b0;
    end else if (!run || restart) begin
      count  <= CNT_ZERO;
      stable <= 1'b0;
    end else if (!stable) begin
      if (count == STAB_LAST) begin
        stable <= 1'b1;
      end else begin
        count <= count + CNT_ONE;
      end
    end
  end

endmodule

// ==== verilog/scmc_top.v ====
// system clock source selection and low-power mode control
//
// Functional notes
// - a halt with both keep-alive bits clear enters the sleep mode.
// - in sleep the processor clock and the slow peripheral clock are both stopped.
// - in sleep the slow internal rc runs only while the watchdog is enabled.
// - a halt with only the slow keep-alive bit set enters idle_slow_only.
// - a halt with both keep-alive bits set enters idle_both_osc.
// - a halt with only the fast keep-alive bit set enters idle_fast_only.
// - sysclk_select codes 000 to 110 divide the fast clock by 1 to 64, code 111 is slow.
// - fast_source_select picks the fast internal rc at 0 and the fast crystal at 1.
// - slow_source_select picks the slow internal rc at 0 and the slow crystal at 1.
// - fast_keep_alive keeps the fast oscillator running once a halt stops the processor.
// - in slow mode each fast oscillator follows its own enable bit.
// - bit 4 of system_clock_control is unimplemented and reads as zero.
// - slow_keep_alive keeps the slow oscillator running once a halt stops the processor.
// - a clock selection change takes effect after four system periods plus a short tail.
// - enabling a fast oscillator clears its stable flag, which sets once it is stable.
`timescale 1ns/1ns
`include "scmc_map.vh"
module scmc_top #(
  parameter STAB_W      = 8,
  parameter STAB_CYCLES = 16
) (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // register port
  input  wire [1:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rdata,
  // processor and system events
  input  wire       halt,
  input  wire       wake,
  input  wire       watchdog_enable,
  // slow oscillator pins
  input  wire       slow_rc_in,
  input  wire       slow_crystal_in,
  // clock enables and status
  output reg        cpu_clk_en,
  output reg        sys_tick,
  output reg        periph_fast_en,
  output reg        periph_slow_en,
  output reg        fast_rc_run,
  output reg        fast_crystal_run,
  output reg        slow_rc_run,
  output reg        slow_crystal_run,
  output reg  [2:0] power_mode,
  output reg  [2:0] active_sysclk_select,
  output reg        active_fast_source,
  output reg        active_slow_source
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  reg rst_meta_n;
  reg rst_n;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // mask of low divider bits that must be zero for a tick at the selected ratio
  function [5:0] scmc_div_mask;
    input [2:0] cks;
    begin
      case (cks)
        3'h0:    scmc_div_mask = 6'h00;
        3'h1:    scmc_div_mask = 6'h01;
        3'h2:    scmc_div_mask = 6'h03;
        3'h3:    scmc_div_mask = 6'h07;
        3'h4:    scmc_div_mask = 6'h0F;
        3'h5:    scmc_div_mask = 6'h1F;
        3'h6:    scmc_div_mask = 6'h3F;
        default: scmc_div_mask = 6'h00;
      endcase
    end
  endfunction

  function scmc_is_fast;
    input [2:0] cks;
    begin
      scmc_is_fast = (cks != `SCMC_CKS_SLOW);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  reg  [2:0] sysclk_select;
  reg        fast_source_select;
  reg        slow_source_select;
  reg        fast_keep_alive;
  reg        slow_keep_alive;
  reg  [1:0] fast_rc_freq;
  reg        fast_rc_en;
  reg        fast_crystal_mode;
  reg        fast_crystal_en;
  reg        slow_crystal_en;
  reg        fast_rc_restart;
  reg        fast_crystal_restart;
  reg        slow_crystal_restart;
  wire       fast_rc_stable_flag;
  wire       fast_crystal_stable_flag;
  wire       slow_crystal_stable_flag;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysclk_select        <= `SCMC_CKS_RST;
      fast_source_select   <= 1'b0;
      slow_source_select   <= 1'b0;
      fast_keep_alive      <= 1'b0;
      slow_keep_alive      <= 1'b0;
      fast_rc_freq         <= `SCMC_FAST_INTERNAL_RC_SEL_RST;
      fast_rc_en           <= `SCMC_FAST_INTERNAL_RC_EN_RST;
      fast_crystal_mode    <= 1'b0;
      fast_crystal_en      <= 1'b0;
      slow_crystal_en      <= 1'b0;
      fast_rc_restart      <= 1'b0;
      fast_crystal_restart <= 1'b0;
      slow_crystal_restart <= 1'b0;
    end else begin
      fast_rc_restart      <= 1'b0;
      fast_crystal_restart <= 1'b0;
      slow_crystal_restart <= 1'b0;
      if (wr_en) begin
        case (addr)
          `SCMC_ADDR_SCC: begin
            sysclk_select      <= wdata[`SCMC_SCC_CKS_HI:`SCMC_SCC_CKS_LO];
            fast_source_select <= wdata[`SCMC_SCC_FHS];
            slow_source_select <= wdata[`SCMC_SCC_FSS];
            fast_keep_alive    <= wdata[`SCMC_SCC_FKEEP];
            slow_keep_alive    <= wdata[`SCMC_SCC_SKEEP];
          end
          `SCMC_ADDR_FAST_RC: begin
            fast_rc_freq <= wdata[`SCMC_FAST_INTERNAL_RC_SEL_HI:`SCMC_FAST_INTERNAL_RC_SEL_LO];
            fast_rc_en   <= wdata[`SCMC_FAST_INTERNAL_RC_EN];
            // a new frequency also has to settle before the flag comes back
            fast_rc_restart <= wdata[`SCMC_FAST_INTERNAL_RC_EN] &
                               (!fast_rc_en |
                                (wdata[`SCMC_FAST_INTERNAL_RC_SEL_HI:`SCMC_FAST_INTERNAL_RC_SEL_LO] != fast_rc_freq));
          end
          `SCMC_ADDR_FAST_XT: begin
            // drive strength is locked while the crystal enable bit is set
            if (!fast_crystal_en) begin
              fast_crystal_mode <= wdata[`SCMC_HXT_MODE];
            end
            fast_crystal_en      <= wdata[`SCMC_HXT_EN];
            fast_crystal_restart <= wdata[`SCMC_HXT_EN] & !fast_crystal_en;
          end
          `SCMC_ADDR_SLOW_XT: begin
            slow_crystal_en      <= wdata[`SCMC_LXT_EN];
            slow_crystal_restart <= wdata[`SCMC_LXT_EN] & !slow_crystal_en;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read data stand for the one cycle after the strobe, zero otherwise
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `SCMC_ZERO8;
    end else if (rd_en) begin
      case (addr)
        `SCMC_ADDR_SCC:
          rdata <= {sysclk_select, 1'b0, fast_source_select,
                    slow_source_select, fast_keep_alive, slow_keep_alive};
        `SCMC_ADDR_FAST_RC:
          rdata <= {4'h0, fast_rc_freq, fast_rc_stable_flag, fast_rc_en};
        `SCMC_ADDR_FAST_XT:
          rdata <= {5'h00, fast_crystal_mode, fast_crystal_stable_flag, fast_crystal_en};
        `SCMC_ADDR_SLOW_XT:
          rdata <= {5'h00, `SCMC_LXT_SPEED_VAL, slow_crystal_stable_flag, slow_crystal_en};
        default:
          rdata <= `SCMC_ZERO8;
      endcase
    end else begin
      rdata <= `SCMC_ZERO8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power mode state machine

  localparam [2:0] ST_RUN   = `SCMC_MODE_RUN;
  localparam [2:0] ST_SLEEP = `SCMC_MODE_SLEEP;
  localparam [2:0] ST_IDLE_SLOW_ONLY = `SCMC_MODE_IDLE_SLOW_ONLY;
  localparam [2:0] ST_IDLE_BOTH_OSC = `SCMC_MODE_IDLE_BOTH_OSC;
  localparam [2:0] ST_IDLE_FAST_ONLY = `SCMC_MODE_IDLE_FAST_ONLY;

  reg [2:0] mode;
  reg [2:0] next_mode;

  // keep-alive bits count only at the halt itself; later writes wait for the next one
  always @* begin
    next_mode = mode;
    case (mode)
      ST_RUN: begin
        if (halt) begin
          case ({fast_keep_alive, slow_keep_alive})
            2'h0:    next_mode = ST_SLEEP;
            2'h1:    next_mode = ST_IDLE_SLOW_ONLY;
            2'h3:    next_mode = ST_IDLE_BOTH_OSC;
            default: next_mode = ST_IDLE_FAST_ONLY;
          endcase
        end
      end
      ST_SLEEP, ST_IDLE_SLOW_ONLY, ST_IDLE_BOTH_OSC, ST_IDLE_FAST_ONLY: begin
        if (wake) begin
          next_mode = ST_RUN;
        end
      end
      default: next_mode = ST_RUN;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= ST_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  wire running   = (mode == ST_RUN);
  wire fast_hold = (mode == ST_IDLE_BOTH_OSC) || (mode == ST_IDLE_FAST_ONLY);
  wire slow_hold = (mode == ST_IDLE_SLOW_ONLY) || (mode == ST_IDLE_BOTH_OSC);

  ////////////////////////////////////////////////////////////////////////////////
  // slow oscillator pins: three stages, a change counts once the last two agree

  wire [1:0] slow_pins = {slow_crystal_in, slow_rc_in};
  wire [1:0] slow_rise;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_slow_sync
      reg [2:0] shift;
      reg       level;
      reg       rise;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          shift <= 3'h0;
          level <= 1'b0;
          rise  <= 1'b0;
        end else begin
          shift <= {shift[1:0], slow_pins[gi]};
          rise  <= 1'b0;
          if (shift[1] == shift[2]) begin
            level <= shift[2];
            rise  <= shift[2] & !level;
          end
        end
      end
      assign slow_rise[gi] = rise;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // system clock tick

  reg [5:0] div_cnt;
  reg       next_sys_tick;

  always @* begin
    next_sys_tick = 1'b0;
    if (running) begin
      if (scmc_is_fast(active_sysclk_select)) begin
        next_sys_tick = ((div_cnt & scmc_div_mask(active_sysclk_select)) == 6'h00);
      end else begin
        next_sys_tick = slow_rise[active_slow_source];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= 6'h00;
      sys_tick <= 1'b0;
    end else begin
      div_cnt  <= running ? (div_cnt + 6'h01) : 6'h00;
      sys_tick <= next_sys_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock switch delay

  wire [4:0] sel_target = {sysclk_select, fast_source_select, slow_source_select};
  reg  [4:0] sel_seen;
  reg  [2:0] sw_periods;
  reg  [1:0] sw_tail;
  reg        sw_busy;

  // a new selection while waiting restarts the wait from its first period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_seen             <= 5'h00;
      sw_periods           <= 3'h0;
      sw_tail              <= 2'h0;
      sw_busy              <= 1'b0;
      active_sysclk_select <= `SCMC_CKS_RST;
      active_fast_source   <= 1'b0;
      active_slow_source   <= 1'b0;
    end else if (sel_target != sel_seen) begin
      sel_seen   <= sel_target;
      sw_periods <= 3'h0;
      sw_tail    <= 2'h0;
      sw_busy    <= 1'b1;
    end else if (sw_busy) begin
      if (sw_periods != `SCMC_SW_SYS_PERIODS) begin
        if (sys_tick) begin
          sw_periods <= sw_periods + 3'h1;
        end
      end else if (sw_tail != `SCMC_SW_TAIL_CYC) begin
        sw_tail <= sw_tail + 2'h1;
      end else begin
        sw_busy              <= 1'b0;
        active_sysclk_select <= sel_seen[4:2];
        active_fast_source   <= sel_seen[1];
        active_slow_source   <= sel_seen[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator and clock enables

  wire fast_mode = running && scmc_is_fast(active_sysclk_select);

  wire next_fast_rc_run = (running && (fast_rc_en || (fast_mode && !active_fast_source))) ||
                          (fast_hold && (fast_rc_en || !active_fast_source));
  wire next_fast_xt_run = (running && (fast_crystal_en || (fast_mode && active_fast_source))) ||
                          (fast_hold && (fast_crystal_en || active_fast_source));
  wire slow_active      = running || slow_hold;
  // the watchdog keeps its rc clock regardless of mode
  wire next_slow_rc_run = watchdog_enable || (slow_active && !active_slow_source);
  wire next_slow_xt_run = slow_active && (active_slow_source || slow_crystal_en);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en       <= 1'b0;
      periph_fast_en   <= 1'b0;
      periph_slow_en   <= 1'b0;
      fast_rc_run      <= 1'b0;
      fast_crystal_run <= 1'b0;
      slow_rc_run      <= 1'b0;
      slow_crystal_run <= 1'b0;
      power_mode       <= `SCMC_MODE_RUN;
    end else begin
      cpu_clk_en       <= running;
      periph_fast_en   <= running || fast_hold;
      periph_slow_en   <= slow_active;
      fast_rc_run      <= next_fast_rc_run;
      fast_crystal_run <= next_fast_xt_run;
      slow_rc_run      <= next_slow_rc_run;
      slow_crystal_run <= next_slow_xt_run;
      power_mode       <= mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stable flags

  wire [2:0] stab_run     = {next_slow_xt_run, next_fast_xt_run, next_fast_rc_run};
  wire [2:0] stab_restart = {slow_crystal_restart, fast_crystal_restart, fast_rc_restart};
  wire [2:0] stab_flag;

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_stab
      scmc_stab #(
        .CNT_W       (STAB_W),
        .STAB_CYCLES (STAB_CYCLES)
      ) u_stab (
        .clk     (clk),
        .rst_n   (rst_n),
        .run     (stab_run[gi]),
        .restart (stab_restart[gi]),
        .stable  (stab_flag[gi])
      );
    end
  endgenerate

  assign fast_rc_stable_flag      = stab_flag[0];
  assign fast_crystal_stable_flag = stab_flag[1];
  assign slow_crystal_stable_flag = stab_flag[2];

endmodule

// ==== testbench/scmc_checker.sv ====
// assertion checker watching the ports of the clock mode control
`timescale 1ns/1ns
module scmc_checker (
  // clock and reset
  input wire       clk,
  input wire       nrst,
  // register port
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] rdata,
  // events
  input wire       halt,
  input wire       wake,
  input wire       watchdog_enable,
  // status
  input wire       cpu_clk_en,
  input wire       periph_fast_en,
  input wire       periph_slow_en,
  input wire       slow_rc_run,
  input wire [2:0] power_mode,
  input wire [2:0] active_sysclk_select
);
  // shadow of the keep-alive bits, since no internal state is visible here
  reg [1:0] keep;
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      keep <= 2'h0;
    else if (wr_en && addr == 2'h0)
      keep <= wdata[1:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_halt(logic [1:0] k);
    halt && power_mode == 3'h0 && !$past(halt) && keep == k ##1 !wake;
  endsequence
  property p_sleep; s_halt(2'h0) |-> ##1 power_mode == 3'h1; endproperty
  property p_idle_slow; s_halt(2'h1) |-> ##1 power_mode == 3'h2; endproperty
  property p_idle_both; s_halt(2'h3) |-> ##1 power_mode == 3'h3; endproperty
  property p_idle_fast; s_halt(2'h2) |-> ##1 power_mode == 3'h4; endproperty
  property p_sleep_gate;
    power_mode == 3'h1 |-> !cpu_clk_en && !periph_slow_en && !periph_fast_en;
  endproperty
  property p_sleep_slow_internal_rc;
    power_mode == 3'h1 && $stable(power_mode) && $stable(watchdog_enable) && !$past(wake)
      |-> slow_rc_run == watchdog_enable;
  endproperty
  property p_slow_gate;
    power_mode == 3'h2 |-> periph_slow_en && !periph_fast_en && !cpu_clk_en;
  endproperty
  property p_both_gate;
    power_mode == 3'h3 |-> periph_slow_en && periph_fast_en && !cpu_clk_en;
  endproperty
  property p_fast_gate;
    power_mode == 3'h4 |-> periph_fast_en && !periph_slow_en && !cpu_clk_en;
  endproperty
  property p_bit4; rd_en && addr == 2'h0 |=> rdata[4] == 1'b0; endproperty
  property p_switch_wait;
    wr_en && addr == 2'h0 |=> $stable(active_sysclk_select) [*5];
  endproperty
  property p_hold;
    power_mode != 3'h0 && !wake && !$past(wake) |=> $stable(power_mode);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  a_idle_slow: assert property (p_idle_slow) else $error("idle slow not entered");
  a_idle_both: assert property (p_idle_both) else $error("idle both not entered");
  a_idle_fast: assert property (p_idle_fast) else $error("idle fast not entered");
  a_sleep_gate: assert property (p_sleep_gate) else $error("clock on in sleep");
  a_sleep_slow_internal_rc: assert property (p_sleep_slow_internal_rc) else $error("slow rc wrong in sleep");
  a_slow_gate: assert property (p_slow_gate) else $error("idle slow gating");
  a_both_gate: assert property (p_both_gate) else $error("idle both gating");
  a_fast_gate: assert property (p_fast_gate) else $error("idle fast gating");
  a_bit4: assert property (p_bit4) else $error("bit 4 not zero");
  a_switch_wait: assert property (p_switch_wait) else $error("switch too early");
  a_hold: assert property (p_hold) else $error("mode left without wake");
  c_sleep_wd: cover property (power_mode == 3'h1 && watchdog_enable);
  c_idle_both: cover property (s_halt(2'h3));
  c_switch: cover property ($changed(active_sysclk_select));
endmodule
bind scmc_top scmc_checker scmc_checker_i (.clk(clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .halt(halt), .wake(wake),
  .watchdog_enable(watchdog_enable), .cpu_clk_en(cpu_clk_en),
  .periph_fast_en(periph_fast_en), .periph_slow_en(periph_slow_en),
  .slow_rc_run(slow_rc_run), .power_mode(power_mode),
  .active_sysclk_select(active_sysclk_select));

// ==== testbench/scmc_top_tb_top.sv ====
// self-checking bench for the clock mode control
`timescale 1ns/1ns
module scmc_top_tb_top;
  // short stabilisation keeps the run brief
  localparam STAB = 2;
  reg        clk = 1'b0;
  reg        nrst = 1'b0;
  reg  [1:0] addr = 2'h0;
  reg  [7:0] wdata = 8'h00;
  reg        wr_en = 1'b0;
  reg        rd_en = 1'b0;
  reg        halt = 1'b0;
  reg        wake = 1'b0;
  reg        watchdog_enable = 1'b0;
  reg        slow_rc_in = 1'b0;
  reg        slow_crystal_in = 1'b0;
  reg  [3:0] rc = 4'h0;
  reg  [3:0] xc = 4'h0;
  reg  [2:0] cks;
  reg  [2:0] pm;
  wire [7:0] rdata;
  wire       cpu_clk_en, sys_tick, periph_fast_en, periph_slow_en;
  wire       fast_rc_run, fast_crystal_run, slow_rc_run, slow_crystal_run;
  wire [2:0] power_mode, active_sysclk_select;
  wire       active_fast_source, active_slow_source;
  integer    n_mismatch = 0, n_checks = 0, cyc = 0, i, k, n, p, p_old;
  scmc_top #(.STAB_CYCLES(STAB)) scmc_top_i (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .halt(halt), .wake(wake),
    .watchdog_enable(watchdog_enable), .slow_rc_in(slow_rc_in),
    .slow_crystal_in(slow_crystal_in), .cpu_clk_en(cpu_clk_en), .sys_tick(sys_tick),
    .periph_fast_en(periph_fast_en), .periph_slow_en(periph_slow_en),
    .fast_rc_run(fast_rc_run), .fast_crystal_run(fast_crystal_run),
    .slow_rc_run(slow_rc_run), .slow_crystal_run(slow_crystal_run),
    .power_mode(power_mode), .active_sysclk_select(active_sysclk_select),
    .active_fast_source(active_fast_source), .active_slow_source(active_slow_source));
  always #50 clk = ~clk;
  // slow pins: rc period 16 cycles, crystal period 10, so the source shows in the tick rate
  always @(posedge clk) begin
    rc <= rc + 4'h1;
    slow_rc_in <= rc[3];
    xc <= (xc == 4'h9) ? 4'h0 : xc + 4'h1;
    slow_crystal_in <= (xc < 4'h5);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
    end
  endtask
  task rd(input [1:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
    end
  endtask
  task hit(input w);
    begin
      @(posedge clk);
      wake <= w;
      halt <= !w;
      @(posedge clk);
      wake <= 1'b0;
      halt <= 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask
  task wsel(input [2:0] c, input fh, input fs);
    begin
      n = 0;
      while ((active_sysclk_select !== c || active_fast_source !== fh ||
              active_slow_source !== fs) && n < 300) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task gap;
    begin
      @(negedge clk);
      n = 1;
      while (sys_tick !== 1'b1 && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h04);
    rd(2'h1, 8'h03);
    p_old = 1;
    for (i = 1; i < 10; i = i + 1) begin
      cks = (i > 8) ? 3'h0 : (i > 6) ? 3'h7 : i[2:0];
      wr(2'h0, {cks, 1'b0, i[0], i == 7, 2'h0});
      wsel(cks, i[0], i == 7);
      chk(n >= 4, 1'b1);
      chk(n <= 4 * p_old + 12, 1'b1);
      chk(active_sysclk_select, cks);
      chk(active_fast_source, i[0]);
      chk(active_slow_source, i == 7);
      p = (i > 8) ? 1 : (i == 7) ? 10 : (i == 8) ? 16 : (1 << i);
      gap;
      gap;
      gap;
      chk(n[7:0], p[7:0]);
      p_old = p;
    end
    wr(2'h0, 8'h1B);
    rd(2'h0, 8'h0B);
    for (k = 0; k < 4; k = k + 1) begin
      wr(2'h0, {6'h02, k[1:0]});
      hit(1'b0);
      pm = (k == 0) ? 3'h1 : (k == 1) ? 3'h2 : (k == 2) ? 3'h4 : 3'h3;
      chk(power_mode, pm);
      chk({cpu_clk_en, periph_fast_en, periph_slow_en}, {1'b0, k[1:0]});
      chk(slow_rc_run, k[0]);
      @(posedge clk);
      watchdog_enable <= 1'b1;
      repeat (3) @(negedge clk);
      chk(slow_rc_run, 1'b1);
      hit(1'b0);
      wr(2'h0, {6'h02, ~k[1:0]});
      chk(power_mode, pm);
      hit(1'b1);
      chk({power_mode, cpu_clk_en}, 4'h1);
      @(posedge clk);
      watchdog_enable <= 1'b0;
    end
    wr(2'h0, 8'hE0);
    wsel(3'h7, 1'b0, 1'b0);
    wr(2'h2, 8'h01);
    rd(2'h2, 8'h01);
    chk(fast_crystal_run, 1'b1);
    // drive mode is locked while the crystal is enabled
    wr(2'h2, 8'h05);
    repeat (STAB + 4) @(negedge clk);
    rd(2'h2, 8'h03);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h00);
    chk({fast_rc_run, fast_crystal_run}, 8'h01);
    wr(2'h1, 8'h01);
    rd(2'h1, 8'h01);
    wr(2'h2, 8'h00);
    wr(2'h3, 8'h01);
    repeat (2) @(negedge clk);
    chk(slow_crystal_run, 1'b1);
    wr(2'h3, 8'h00);
    rd(2'h3, 8'h04);
    chk(slow_crystal_run, 1'b0);
    repeat (STAB + 4) @(negedge clk);
    rd(2'h1, 8'h03);
    chk(fast_crystal_run, 1'b0);
    results;
  end
endmodule
